//--- dv/lsi_link_props.sv
`timescale 1ns/1ps
module lsi_link_props (
  input wire logic pclk,
  input wire logic link_clk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda,
  input wire logic hs_mode
);
  // ****************************************
  // Wire shape seen from the host clock
  // ****************************************
  sequence s_start;
    scl && $rose(host_sda_oe);
  endsequence
  sequence s_scl_held;
    scl [*8];
  endsequence
  a_start_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_start |-> ##1 s_scl_held) else $error("start condition too short");
  a_scl_high_min: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(scl) |-> s_scl_held) else $error("clock high phase too short");
  a_scl_low_min: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(scl) |=> !scl [*7]) else $error("clock low phase too short");
  // Host may hold the clock low between commands, but it must rise within 1000 host clocks of each fall
  a_scl_low_max: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(scl) |-> ##[1:1000] scl) else $error("clock stuck low");
  // ****************************************
  // Device behaviour seen from the link clock
  // ****************************************
  // Device data may only move while the clock is low, in either speed
  a_dev_hold_high: assert property (@(posedge link_clk) disable iff (!presetn)
    scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("data moved, clock high");
  a_dev_rise_low: assert property (@(posedge link_clk) disable iff (!presetn)
    $rose(dev_sda_oe) |-> !scl) else $error("device drove data, clock high");
  a_hs_exit_stop: assert property (@(posedge link_clk) disable iff (!presetn)
    $fell(hs_mode) |-> scl && sda) else $error("high speed left without stop");
  a_hs_no_ack: assert property (@(posedge link_clk) disable iff (!presetn)
    $rose(hs_mode) |=> !dev_sda_oe [*4]) else $error("master code acknowledged");
endmodule // lsi_link_props

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "lsi_defs.svh"
module tb_top
  import lsi_pkg::*;
;
  localparam logic [15:0] MAKER  = 16'h5A5A; // Arbitrary value
  localparam logic [7:0]  ADDR_W = {`LSI_DEV_ADDR, 1'b0};
  logic        pclk         = 1'b0;
  logic        link_clk     = 1'b0;
  logic        presetn      = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [11:0] paddr        = 12'h000;
  logic [31:0] pwdata       = 32'h00000000;
  logic [15:0] result_value = 16'h0000;
  logic        result_load  = 1'b0;
  logic [3:0]  status_flags = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] setup_value;
  logic        hs_mode;
  int          fails        = 0;
  int          check_count  = 0;
  // Two unrelated clocks; the link clock starts off phase
  always #4 pclk = ~pclk;
  initial #13 forever #40 link_clk = ~link_clk;
  lsi_if lsi_if_i ();
  lsi_host lsi_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lsi_if_i));
  lsi_dev #(.MAKER_ID(MAKER)) lsi_dev_i (.link_clk(link_clk), .presetn(presetn),
    .link(lsi_if_i), .result_value(result_value), .result_load(result_load),
    .status_flags(status_flags), .setup_value(setup_value), .hs_mode(hs_mode));
  lsi_link_props lsi_link_props_i (.pclk(pclk), .link_clk(link_clk), .presetn(presetn),
    .scl(lsi_if_i.scl), .host_sda_oe(lsi_if_i.host_sda_oe), .dev_sda_oe(lsi_if_i.dev_sda_oe),
    .sda(lsi_if_i.sda), .hs_mode(hs_mode));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic final_report();
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      final_report();
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issue one serial command and poll until the host is idle again
  task automatic cmd(input logic [2:0] op, input logic [7:0] b, output logic [31:0] st);
    logic err;
    int   n = 0;
    apb(1'b1, `LSI_CMD_OFF, {16'h0000, b, 5'h00, op}, st, err);
    do begin
      apb(1'b0, `LSI_STAT_OFF, 32'h0, st, err);
      n++;
    end while (st[0] !== 1'b0 && n < 4000);
    if (n >= 4000) begin
      fails++;
      final_report();
    end
  endtask
  task automatic send(input logic [7:0] b, input logic ack, input string name);
    logic [31:0] st;
    cmd(`LSI_OP_WRITE, b, st);
    check(name, ack, st[1]);
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] v);
    logic [31:0] st;
    cmd(`LSI_OP_START, 8'h00, st);
    send(ADDR_W, 1'b1, "addr ack");
    send(ptr, 1'b1, "ptr ack");
    send(v[15:8], 1'b1, "upper ack");
    send(v[7:0], 1'b1, "lower ack");
    cmd(`LSI_OP_STOP, 8'h00, st);
  endtask
  // Without set_ptr the device must use its retained pointer
  task automatic rd_reg(input logic set_ptr, input logic [7:0] ptr, output logic [15:0] v);
    logic [31:0] st;
    cmd(`LSI_OP_START, 8'h00, st);
    if (set_ptr) begin
      send(ADDR_W, 1'b1, "addr ack");
      send(ptr, 1'b1, "ptr ack");
      cmd(`LSI_OP_START, 8'h00, st);
    end
    send(ADDR_W | 8'h01, 1'b1, "read addr ack");
    cmd(`LSI_OP_RD_ACK, 8'h00, st);
    v[15:8] = st[15:8];
    cmd(`LSI_OP_RD_NACK, 8'h00, st);
    v[7:0] = st[15:8];
    cmd(`LSI_OP_STOP, 8'h00, st);
  endtask
  task automatic wait_hs(input logic lvl);
    int n;
    for (n = 0; n < 50 && hs_mode !== lvl; n++) @(posedge link_clk);
    if (n >= 50) begin
      fails++;
      final_report();
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [31:0] q;
    logic        err;
    check("setup reset", `LSI_SETUP_RST, setup_value);
    check("hs reset", 1'b0, hs_mode);
    check("idle wire", 2'b11, {lsi_if_i.scl, lsi_if_i.sda});
    apb(1'b0, 12'h008, 32'h0, q, err);
    check("unmapped err", 1'b1, err);
    check("unmapped data", 32'h0, q);
  endtask
  task automatic t_lower();
    logic [15:0] v;
    wr_reg(`LSI_PTR_LOWER, 16'hA55A);
    rd_reg(1'b1, `LSI_PTR_LOWER, v);
    check("lower threshold", 16'hA55A, v);
  endtask
  // Masked scale under a manual range; result ignores writes
  task automatic t_mask();
    logic [15:0] v;
    @(posedge link_clk);
    result_value <= {4'h3, 12'h456};
    result_load  <= 1'b1;
    @(posedge link_clk);
    result_value <= {4'hD, 12'hFFF};
    @(posedge link_clk);
    result_load  <= 1'b0;
    wr_reg(`LSI_PTR_SETUP, {4'h3, 12'h004});
    check("setup write", 16'h3004 & `LSI_SETUP_WMASK, setup_value);
    wr_reg(`LSI_PTR_RESULT, 16'hFFFF);
    rd_reg(1'b0, 8'h00, v);
    check("masked result", {4'h0, 12'h456}, v);
  endtask
  task automatic t_maker();
    logic [15:0] v;
    rd_reg(1'b1, `LSI_PTR_MAKER, v);
    check("maker code", MAKER, v);
  endtask
  task automatic t_high_speed();
    logic [31:0] st;
    cmd(`LSI_OP_START, 8'h00, st);
    cmd(`LSI_OP_WRITE, {`LSI_HS_CODE, 3'h5}, st);
    check("master code ack", 1'b0, st[1]);
    check("host hs", 1'b1, st[2]);
    wait_hs(1'b1);
    check("hs entered", 1'b1, hs_mode);
    cmd(`LSI_OP_START, 8'h00, st);
    send(ADDR_W, 1'b1, "hs addr ack");
    check("hs held", 1'b1, hs_mode);
    cmd(`LSI_OP_STOP, 8'h00, st);
    check("host hs left", 1'b0, st[2]);
    wait_hs(1'b0);
    check("hs left", 1'b0, hs_mode);
  endtask
  task automatic t_gcall();
    logic [31:0] st;
    int          n;
    cmd(`LSI_OP_START, 8'h00, st);
    send({7'h49, 1'b0}, 1'b0, "other addr ack");
    cmd(`LSI_OP_START, 8'h00, st);
    send(`LSI_GCALL_ADDR, 1'b1, "gcall ack");
    send(`LSI_GCALL_RST, 1'b1, "gcall reset ack");
    cmd(`LSI_OP_STOP, 8'h00, st);
    for (n = 0; n < 50 && setup_value !== `LSI_SETUP_RST; n++) @(posedge link_clk);
    check("setup restored", `LSI_SETUP_RST, setup_value);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge link_clk);
    t_reset();
    t_lower();
    t_mask();
    t_maker();
    t_high_speed();
    t_gcall();
    final_report();
  end
endmodule // tb_top

//--- logic/lsi_defs.svh
`ifndef LSI_DEFS_SVH
`define LSI_DEFS_SVH
// Behaviour
// - Master code sent slow; no ack, enter HS
// - After restart, same protocol at HS rate
// - Master stays in HS using repeated starts
// - Stop leaves HS, filters back to F/S
// - General call 06h acks, restores defaults
// - All registers sixteen bits wide
// - Register bytes move upper byte first
// - Pointer decode 00h to 03h, threshold fields
// - Read-only ID registers at 7Eh, 7Fh
// - Result holds latest conversion, scale and count
// - Result read-only, resets to zero
// - Count is unsigned straight binary
// - Scale codes 0 to 11 only
// - Mask zeroes scale under manual range
// - Slave answers at fixed seven-bit address
// - First write byte loads retained pointer

// ********************************
// Bus and register map
// ********************************
`define LSI_DEV_ADDR    7'h45
`define LSI_GCALL_ADDR  8'h00
`define LSI_GCALL_RST   8'h06
`define LSI_HS_CODE     5'h01
`define LSI_PTR_RESULT  8'h00
`define LSI_PTR_SETUP   8'h01
`define LSI_PTR_LOWER   8'h02
`define LSI_PTR_UPPER   8'h03
`define LSI_PTR_MAKER   8'h7E
`define LSI_PTR_PART    8'h7F
`define LSI_SETUP_RST   16'hC810
`define LSI_SETUP_WMASK 16'hFE1F
`define LSI_LOWER_RST   16'h0000
`define LSI_UPPER_RST   16'hFFFF
`define LSI_SCALE_MAX   4'hB
`define LSI_SCALE_AUTO  4'hC
`define LSI_MASK_BIT    2
// ********************************
// Host command port
// ********************************
`define LSI_CMD_OFF     12'h000
`define LSI_STAT_OFF    12'h004
`define LSI_OP_START    3'h1
`define LSI_OP_WRITE    3'h2
`define LSI_OP_RD_ACK   3'h3
`define LSI_OP_RD_NACK  3'h4
`define LSI_OP_STOP     3'h5
// ********************************
// Timing
// ********************************
`define LSI_PCLK_NS     8
`define LSI_FS_PER_NS   2500
// HS rate stays under its ceiling: the slave answers about four link clocks
// after a clock fall, so each half must outlast that or data moves while high
`define LSI_HS_PER_NS   1000
`define LSI_FS_HALF     8'((`LSI_FS_PER_NS + 2 * `LSI_PCLK_NS - 1) / (2 * `LSI_PCLK_NS))
`define LSI_HS_HALF     8'((`LSI_HS_PER_NS + 2 * `LSI_PCLK_NS - 1) / (2 * `LSI_PCLK_NS))
`endif

//--- logic/lsi_dev.sv
`timescale 1ns/1ps
`include "lsi_defs.svh"
module lsi_dev
  import lsi_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h5A5A, // Arbitrary value
  parameter logic [15:0] PART_ID  = 16'h0001  // Arbitrary value
) (
  input  wire logic        link_clk,
  input  wire logic        presetn,
  lsi_if.dev               link,
  input  wire logic [15:0] result_value,
  input  wire logic        result_load,
  input  wire logic [3:0]  status_flags,
  output logic      [15:0] setup_value,
  output logic             hs_mode
);

  // ********************************
  // Pin synchronisers and filters
  // ********************************
  logic scl_m, scl_s, scl_p, scl_f, scl_fd;
  logic sda_m, sda_s, sda_p, sda_f, sda_fd;
  logic rise, fall, start_c, stop_c;

  // Two flops per pin; first stage read only by the second
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      {scl_s, scl_m} <= 2'h3;
      {sda_s, sda_m} <= 2'h3;
    end else begin
      {scl_s, scl_m} <= {scl_m, link.scl};
      {sda_s, sda_m} <= {sda_m, link.sda};
    end
  end

  // F/S needs two agreeing samples; HS takes every sample to keep up
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      scl_p  <= 1'b1;
      sda_p  <= 1'b1;
      scl_f  <= 1'b1;
      sda_f  <= 1'b1;
      scl_fd <= 1'b1;
      sda_fd <= 1'b1;
    end else begin
      scl_p  <= scl_s;
      sda_p  <= sda_s;
      scl_fd <= scl_f;
      sda_fd <= sda_f;
      if (hs_mode || scl_s == scl_p) begin
        scl_f <= scl_s;
      end
      if (hs_mode || sda_s == sda_p) begin
        sda_f <= sda_s;
      end
    end
  end

  // Bus events from the filtered levels
  assign rise    = scl_f & ~scl_fd;
  assign fall    = ~scl_f & scl_fd;
  assign start_c = scl_f & scl_fd & sda_fd & ~sda_f;
  assign stop_c  = scl_f & scl_fd & ~sda_fd & sda_f;

  // ********************************
  // Register bank
  // ********************************
  logic [15:0] result_q, lower_q, upper_q;
  logic [15:0] rd_word, wdata;
  logic [7:0]  ptr;
  logic        wr_en, gc_rst;

  // Read decode; the mask hides the scale under a manual range
  function automatic logic [15:0] reg_read(input logic [7:0] p);
    logic [3:0] sc;
    sc = result_q[15:12];
    if (setup_value[`LSI_MASK_BIT] && setup_value[15:12] < `LSI_SCALE_AUTO) begin
      sc = 4'h0;
    end
    case (p)
      `LSI_PTR_RESULT: reg_read = {sc, result_q[11:0]};
      `LSI_PTR_SETUP:  reg_read = {setup_value[15:9], status_flags, setup_value[4:0]};
      `LSI_PTR_LOWER:  reg_read = lower_q;
      `LSI_PTR_UPPER:  reg_read = upper_q;
      `LSI_PTR_MAKER:  reg_read = MAKER_ID;
      `LSI_PTR_PART:   reg_read = PART_ID;
      default:         reg_read = 16'h0000;
    endcase
  endfunction

  assign rd_word = reg_read(ptr);

  // Writes and defaults; general call acts like power-on
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      result_q    <= 16'h0000;
      setup_value <= `LSI_SETUP_RST;
      lower_q     <= `LSI_LOWER_RST;
      upper_q     <= `LSI_UPPER_RST;
    end else if (gc_rst) begin
      result_q    <= 16'h0000;
      setup_value <= `LSI_SETUP_RST;
      lower_q     <= `LSI_LOWER_RST;
      upper_q     <= `LSI_UPPER_RST;
    end else begin
      // Out-of-range scale codes are dropped, the old result stays
      if (result_load && result_value[15:12] <= `LSI_SCALE_MAX) begin
        result_q <= result_value;
      end
      if (wr_en) begin
        case (ptr)
          `LSI_PTR_SETUP: begin
            setup_value <= (setup_value & ~`LSI_SETUP_WMASK)
                         | (wdata & `LSI_SETUP_WMASK);
          end
          `LSI_PTR_LOWER: lower_q <= wdata;
          `LSI_PTR_UPPER: upper_q <= wdata;
          default: ;
        endcase
      end
    end
  end

  // ********************************
  // Byte engine
  // ********************************
  lsi_dev_st_type st;
  lsi_kind_type   kind;
  logic [3:0]     bitcnt;
  logic [7:0]     sh;
  logic [7:0]     msb_hold;
  logic           lsb_next, nack;
  logic           sda_oe_q;

  assign link.dev_sda_oe = sda_oe_q;

  // Start and stop win over any bit activity
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      st       <= D_IDLE;
      kind     <= K_ADDR;
      bitcnt   <= 4'h0;
      sh       <= 8'h00;
      msb_hold <= 8'h00;
      sda_oe_q <= 1'b0;
      hs_mode  <= 1'b0;
      ptr      <= 8'h00;
      lsb_next <= 1'b0;
      nack     <= 1'b0;
      wr_en    <= 1'b0;
      wdata    <= 16'h0000;
      gc_rst   <= 1'b0;
    end else begin
      wr_en  <= 1'b0;
      gc_rst <= 1'b0;
      if (stop_c) begin
        st       <= D_IDLE;
        sda_oe_q <= 1'b0;
        hs_mode  <= 1'b0;
      end else if (start_c) begin
        st       <= D_RECV;
        kind     <= K_ADDR;
        bitcnt   <= 4'h0;
        sda_oe_q <= 1'b0;
      end else begin
        case (st)
          D_RECV: begin
            if (rise) begin
              if (bitcnt < 4'h8) begin
                sh <= {sh[6:0], sda_f};
              end
              bitcnt <= bitcnt + 4'h1;
            end else if (fall && bitcnt == 4'h8) begin
              sda_oe_q <= 1'b1;
              case (kind)
                K_ADDR: begin
                  if (sh[7:1] == `LSI_DEV_ADDR) begin
                    kind <= sh[0] ? K_READ : K_PTR;
                  end else if (sh == `LSI_GCALL_ADDR) begin
                    kind <= K_GCALL;
                  end else begin
                    sda_oe_q <= 1'b0;
                    st       <= D_IDLE;
                    if (sh[7:3] == `LSI_HS_CODE) begin
                      hs_mode <= 1'b1;
                    end
                  end
                end
                K_PTR: begin
                  ptr  <= sh;
                  kind <= K_MSB;
                end
                K_MSB: begin
                  msb_hold <= sh;
                  kind     <= K_LSB;
                end
                K_LSB: begin
                  wdata <= {msb_hold, sh};
                  wr_en <= 1'b1;
                  kind  <= K_MSB;
                end
                K_GCALL: begin
                  if (sh == `LSI_GCALL_RST) begin
                    gc_rst <= 1'b1;
                    kind   <= K_DONE;
                  end else begin
                    sda_oe_q <= 1'b0;
                    st       <= D_IDLE;
                  end
                end
                default: begin
                  sda_oe_q <= 1'b0;
                  st       <= D_IDLE;
                end
              endcase
            end else if (fall && bitcnt == 4'h9) begin
              bitcnt <= 4'h0;
              if (kind == K_READ) begin
                st       <= D_SEND;
                sh       <= rd_word[15:8];
                sda_oe_q <= ~rd_word[15];
                lsb_next <= 1'b1;
              end else if (kind == K_DONE) begin
                st       <= D_IDLE;
                sda_oe_q <= 1'b0;
              end else begin
                sda_oe_q <= 1'b0;
              end
            end
          end
          D_SEND: begin
            if (rise) begin
              if (bitcnt == 4'h8) begin
                nack <= sda_f;
              end
              bitcnt <= bitcnt + 4'h1;
            end else if (fall) begin
              if (bitcnt < 4'h8) begin
                sh       <= {sh[6:0], 1'b0};
                sda_oe_q <= ~sh[6];
              end else if (bitcnt == 4'h8) begin
                sda_oe_q <= 1'b0;
              end else if (nack) begin
                st <= D_IDLE;
              end else begin
                // Upper then lower, then the same word again
                bitcnt   <= 4'h0;
                lsb_next <= ~lsb_next;
                sh       <= lsb_next ? rd_word[7:0] : rd_word[15:8];
                sda_oe_q <= lsb_next ? ~rd_word[7] : ~rd_word[15];
              end
            end
          end
          default: begin
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // lsi_dev

//--- logic/lsi_host.sv
`timescale 1ns/1ps
`include "lsi_defs.svh"
module lsi_host
  import lsi_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  lsi_if.host              link
);

  // ********************************
  // APB slave, one wait-free access
  // ********************************
  lsi_host_st_type st;
  logic            access, busy, ack, hs, first_byte, scl_q, oe_q;
  logic [7:0]      rx, tx, div;
  logic [4:0]      step;
  logic [2:0]      op;
  logic            sda_m, sda_s;

  assign access = psel & penable & pready;
  assign link.scl         = scl_q;
  assign link.host_sda_oe = oe_q;

  // Answer is prepared in the setup cycle so outputs stay registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & paddr != `LSI_CMD_OFF & paddr != `LSI_STAT_OFF;
      if (psel && !penable && paddr == `LSI_STAT_OFF) begin
        prdata <= {16'h0000, rx, 5'h00, hs, ack, busy};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Data pin crosses in from the wire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sda_s, sda_m} <= 2'h3;
    end else begin
      {sda_s, sda_m} <= {sda_m, link.sda};
    end
  end

  // ********************************
  // Serial clock divider
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= `LSI_FS_HALF - 8'h01;
    end else if (st == H_IDLE || div == 8'h00) begin
      div <= (hs ? `LSI_HS_HALF : `LSI_FS_HALF) - 8'h01;
    end else begin
      div <= div - 8'h01;
    end
  end

  // ********************************
  // Bit sequencer
  // ********************************
  // No clock stretching: the slave must keep pace with the divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st         <= H_IDLE;
      step       <= 5'h00;
      op         <= 3'h0;
      tx         <= 8'h00;
      rx         <= 8'h00;
      ack        <= 1'b0;
      hs         <= 1'b0;
      first_byte <= 1'b0;
      busy       <= 1'b0;
      scl_q      <= 1'b1;
      oe_q       <= 1'b0;
    end else begin
      case (st)
        H_IDLE: begin
          step <= 5'h00;
          if (access && pwrite && paddr == `LSI_CMD_OFF) begin
            op   <= pwdata[2:0];
            tx   <= pwdata[15:8];
            busy <= 1'b1;
            case (pwdata[2:0])
              `LSI_OP_START: begin
                st   <= H_START;
                oe_q <= 1'b0;
              end
              `LSI_OP_WRITE: begin
                st   <= H_BYTE;
                oe_q <= ~pwdata[15];
              end
              `LSI_OP_RD_ACK, `LSI_OP_RD_NACK: begin
                st   <= H_BYTE;
                oe_q <= 1'b0;
              end
              `LSI_OP_STOP: begin
                st   <= H_STOP;
                oe_q <= 1'b1;
              end
              default: busy <= 1'b0;
            endcase
          end
        end
        H_START: begin
          if (div == 8'h00) begin
            step <= step + 5'h01;
            case (step)
              5'h00:   scl_q <= 1'b1;
              5'h01:   oe_q <= 1'b1;
              default: begin
                scl_q      <= 1'b0;
                first_byte <= 1'b1;
                busy       <= 1'b0;
                st         <= H_IDLE;
              end
            endcase
          end
        end
        H_BYTE: begin
          if (div == 8'h00) begin
            step <= step + 5'h01;
            if (!step[0]) begin
              scl_q <= 1'b1;
            end else begin
              scl_q <= 1'b0;
              if (step < 5'h10) begin
                rx   <= {rx[6:0], sda_s};
                tx   <= {tx[6:0], 1'b0};
                oe_q <= (op == `LSI_OP_WRITE) & ~tx[6];
              end
              if (step == 5'h0F) begin
                oe_q <= (op == `LSI_OP_RD_ACK);
              end
              if (step == 5'h11) begin
                ack        <= ~sda_s;
                oe_q       <= 1'b0;
                busy       <= 1'b0;
                first_byte <= 1'b0;
                st         <= H_IDLE;
                if (first_byte && op == `LSI_OP_WRITE && rx[7:3] == `LSI_HS_CODE) begin
                  hs <= 1'b1;
                end
              end
            end
          end
        end
        H_STOP: begin
          if (div == 8'h00) begin
            step <= step + 5'h01;
            case (step)
              5'h00:   scl_q <= 1'b1;
              5'h01:   oe_q <= 1'b0;
              default: begin
                hs   <= 1'b0;
                busy <= 1'b0;
                st   <= H_IDLE;
              end
            endcase
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end

endmodule // lsi_host

//--- logic/lsi_if.sv
`timescale 1ns/1ps
interface lsi_if;
  logic scl;          // Serial clock, made by the host
  logic host_sda_oe;  // Host pulls data low
  logic dev_sda_oe;   // Device pulls data low
  logic sda;          // Open-drain wire level
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport host (output scl, output host_sda_oe, input sda);
  modport dev  (input scl, output dev_sda_oe, input sda);
endinterface // lsi_if

//--- logic/lsi_pkg.sv
package lsi_pkg;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} lsi_host_st_type;
  typedef enum logic [1:0] {D_IDLE, D_RECV, D_SEND} lsi_dev_st_type;
  typedef enum logic [2:0] {
    K_ADDR, K_PTR, K_MSB, K_LSB, K_GCALL, K_READ, K_DONE
  } lsi_kind_type;
endpackage
